//--- src/brake_seq_map.svh
// register offsets, field limits, codes and timing constants of the brake sequencer
`ifndef BRAKE_SEQ_MAP_SVH
`define BRAKE_SEQ_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CMD     8'h00
`define OFF_DEXC    8'h04
`define OFF_THR     8'h08
`define OFF_WAIT    8'h0c
`define OFF_MODE    8'h10
`define OFF_MAXSPD  8'h14
`define OFF_STATUS  8'h18

// ----------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------
`define SEL_CMD     3'h0
`define SEL_DEXC    3'h1
`define SEL_THR     3'h2
`define SEL_WAIT    3'h3
`define SEL_MODE    3'h4
`define SEL_MAXSPD  3'h5
`define SEL_STATUS  3'h6
`define SEL_NONE    3'h7

// ----------------------------------------------------------------
// host command codes
// ----------------------------------------------------------------
`define CMD_SERVO_ON   8'h31
`define CMD_SERVO_OFF  8'h32

// ----------------------------------------------------------------
// setting limits and reset values
// ----------------------------------------------------------------
`define DEXC_RST    32'h0000_0000
`define DEXC_MAX    32'h0000_0032
`define THR_RST     32'h0000_0064
`define THR_MAX     32'h0000_2710
`define WAIT_RST    32'h0000_0032
`define WAIT_MIN    32'h0000_000a
`define WAIT_MAX    32'h0000_0064
`define MAXSPD_RST  32'h0000_1770
`define STILL_RPM   16'h0014
`define MODE_ZERO   0

// ----------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------
`define ST_STATE_LO 0
`define ST_STATE_HI 2
`define ST_BRK      3
`define ST_EXC      4
`define ST_ZERO     5
`define ST_STILL    6
`define ST_ALARM    7

// ----------------------------------------------------------------
// bus responses and timing
// ----------------------------------------------------------------
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10
`define TICK_PERIOD_NS 10000000
`define CLK_PERIOD_NS  10

`endif

//--- src/brake_seq_pkg.sv
// types shared by the brake sequencer files
package brake_seq_pkg;

   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF        = 3'b000,
      ST_RUN        = 3'b001,
      ST_STOP_DELAY = 3'b010,
      ST_ROT_COAST  = 3'b011,
      ST_ZERO_DECEL = 3'b100
   } st_e;

   // ----------------------------------------------------------------
   // axi4-lite request and response bundles
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } axi_rsp_s;

   // ----------------------------------------------------------------
   // software settings
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [5:0] dexc;
      logic [15:0] thr;
      logic [6:0] wait_t;
      logic zero_sel;
      logic [15:0] max_spd;
   } cfg_s;

endpackage

//--- src/tick_gen.sv
// restartable 10 ms time base
`timescale 1ns/1ps
module tick_gen #(
   parameter int TICK_CYCLES = 1000000
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // control and tick
   input wire logic restart,
   output logic tick
);
   localparam int CNT_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

   logic [CNT_W-1:0] cnt;

   // count one base period, pulse at its end, realign on restart
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (restart) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (cnt == LAST) begin
         cnt <= '0;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule

//--- src/delay_timer.sv
// countdown of whole time-base ticks with a sticky expiry flag
`timescale 1ns/1ps
module delay_timer #(
   parameter int CNT_W = 7
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // control
   input wire logic start,
   input wire logic [CNT_W-1:0] load,
   input wire logic tick,
   // result
   output logic expired
);
   logic [CNT_W-1:0] count;
   logic running;

   // load on start, count ticks down, flag when zero is reached
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
         running <= 1'b0;
         expired <= 1'b0;
      end else if (start) begin
         count <= load;
         running <= 1'b1;
         expired <= 1'b0;
      end else if (running) begin
         if (count == '0) begin
            running <= 1'b0;
            expired <= 1'b1;
         end else if (tick) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

//--- src/brake_seq.sv
// holding brake timing sequencer with axi4-lite settings
//
// Behaviour
// - a servo-off command at standstill engages the brake output at once.
// - standstill servo-off keeps excitation 0..50 x 10 ms, default 0.
// - only a stopped motor uses that delay; rotation uses speed and wait.
// - an alarm during rotation, unless it is a zero-speed class-2 stop, is a rotating stop: coast, then brake on speed or wait.
// - rotating stop: brake once speed is below 0..10000 rpm, default 100.
// - rotating stop: also brake after a 10..100 x 10 ms wait, default 50.
// - a threshold above the motor maximum speed is cut to that maximum.
// - zero-speed class-2 stop: decelerate first, then standstill delay.
`timescale 1ns/1ps
`include "brake_seq_map.svh"
module brake_seq
   import brake_seq_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // register bus
   input wire axi_req_s axi_req,
   output axi_rsp_s axi_rsp,
   // motor drive side
   input wire logic [15:0] motor_speed,
   input wire logic alarm_stop,
   input wire logic alarm_class2,
   output logic brake_release,
   output logic excite,
   output logic zero_speed_cmd
);

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // map a byte address onto a register select code
   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      case (a)
         `OFF_CMD: reg_sel = `SEL_CMD;
         `OFF_DEXC: reg_sel = `SEL_DEXC;
         `OFF_THR: reg_sel = `SEL_THR;
         `OFF_WAIT: reg_sel = `SEL_WAIT;
         `OFF_MODE: reg_sel = `SEL_MODE;
         `OFF_MAXSPD: reg_sel = `SEL_MAXSPD;
         `OFF_STATUS: reg_sel = `SEL_STATUS;
         default: reg_sel = `SEL_NONE;
      endcase
   endfunction

   // apply byte enables of a write onto an old word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   // hold a written value inside its setting range
   function automatic logic [31:0] clamp(input logic [31:0] v,
                                         input logic [31:0] lo,
                                         input logic [31:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   cfg_s cfg;
   st_e state, next_state;
   logic [7:0] aw_addr, last_cmd;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [2:0] wsel, rsel;
   logic wr_fire, cmd_off, cmd_on;
   logic standstill, zero_stop, stop_hit;
   logic [15:0] eff_thr;
   logic tmr_start, tmr_expired, tick;
   logic [6:0] tmr_load;
   logic [31:0] status_word;

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   assign wsel = reg_sel(aw_addr);
   assign wr_fire = !axi_rsp.awready && !axi_rsp.wready && !axi_rsp.bvalid;

   // take address and data in either order, answer once both are held
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         axi_rsp.awready <= 1'b1;
         axi_rsp.wready <= 1'b1;
         axi_rsp.bvalid <= 1'b0;
         axi_rsp.bresp <= `RESP_OKAY;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (axi_req.awvalid && axi_rsp.awready) begin
            aw_addr <= axi_req.awaddr;
            axi_rsp.awready <= 1'b0;
         end
         if (axi_req.wvalid && axi_rsp.wready) begin
            w_data <= axi_req.wdata;
            w_strb <= axi_req.wstrb;
            axi_rsp.wready <= 1'b0;
         end
         if (wr_fire) begin
            axi_rsp.bvalid <= 1'b1;
            axi_rsp.bresp <= (wsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
         end else if (axi_rsp.bvalid && axi_req.bready) begin
            axi_rsp.bvalid <= 1'b0;
            axi_rsp.awready <= 1'b1;
            axi_rsp.wready <= 1'b1;
         end
      end
   end

   // settings take effect on the write itself, no restart needed
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg.dexc <= 6'(`DEXC_RST);
         cfg.thr <= 16'(`THR_RST);
         cfg.wait_t <= 7'(`WAIT_RST);
         cfg.zero_sel <= 1'b0;
         cfg.max_spd <= 16'(`MAXSPD_RST);
      end else if (wr_fire) begin
         case (wsel)
            `SEL_DEXC: cfg.dexc <= 6'(clamp(merge({26'h0, cfg.dexc},
               w_data, w_strb), `DEXC_RST, `DEXC_MAX));
            `SEL_THR: cfg.thr <= 16'(clamp(merge({16'h0, cfg.thr},
               w_data, w_strb), 32'h0, `THR_MAX));
            `SEL_WAIT: cfg.wait_t <= 7'(clamp(merge({25'h0, cfg.wait_t},
               w_data, w_strb), `WAIT_MIN, `WAIT_MAX));
            `SEL_MODE: if (w_strb[0]) cfg.zero_sel <= w_data[`MODE_ZERO];
            `SEL_MAXSPD: cfg.max_spd <= 16'(merge({16'h0, cfg.max_spd},
               w_data, w_strb));
            default: ;
         endcase
      end
   end

   // host commands become one-cycle pulses for the sequencer
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         last_cmd <= 8'h00;
         cmd_off <= 1'b0;
         cmd_on <= 1'b0;
      end else begin
         cmd_off <= 1'b0;
         cmd_on <= 1'b0;
         if (wr_fire && wsel == `SEL_CMD && w_strb[0]) begin
            last_cmd <= w_data[7:0];
            cmd_off <= (w_data[7:0] == `CMD_SERVO_OFF);
            cmd_on <= (w_data[7:0] == `CMD_SERVO_ON);
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   assign rsel = reg_sel(axi_req.araddr);

   // status word gathers the live sequencer state
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`ST_STATE_HI:`ST_STATE_LO] = state;
      status_word[`ST_BRK] = brake_release;
      status_word[`ST_EXC] = excite;
      status_word[`ST_ZERO] = zero_speed_cmd;
      status_word[`ST_STILL] = standstill;
      status_word[`ST_ALARM] = alarm_stop;
   end

   // answer a read one cycle after the address is taken
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         axi_rsp.arready <= 1'b1;
         axi_rsp.rvalid <= 1'b0;
         axi_rsp.rdata <= 32'h0000_0000;
         axi_rsp.rresp <= `RESP_OKAY;
      end else if (axi_req.arvalid && axi_rsp.arready) begin
         axi_rsp.arready <= 1'b0;
         axi_rsp.rvalid <= 1'b1;
         axi_rsp.rresp <= (rsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
         case (rsel)
            `SEL_CMD: axi_rsp.rdata <= {24'h0, last_cmd};
            `SEL_DEXC: axi_rsp.rdata <= {26'h0, cfg.dexc};
            `SEL_THR: axi_rsp.rdata <= {16'h0, cfg.thr};
            `SEL_WAIT: axi_rsp.rdata <= {25'h0, cfg.wait_t};
            `SEL_MODE: axi_rsp.rdata <= {31'h0, cfg.zero_sel};
            `SEL_MAXSPD: axi_rsp.rdata <= {16'h0, cfg.max_spd};
            `SEL_STATUS: axi_rsp.rdata <= status_word;
            default: axi_rsp.rdata <= 32'h0000_0000;
         endcase
      end else if (axi_rsp.rvalid && axi_req.rready) begin
         axi_rsp.rvalid <= 1'b0;
         axi_rsp.arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // motion conditions
   // ----------------------------------------------------------------
   assign standstill = (motor_speed < `STILL_RPM);
   assign eff_thr = (cfg.thr > cfg.max_spd) ? cfg.max_spd : cfg.thr;
   assign zero_stop = alarm_stop && alarm_class2 && cfg.zero_sel;
   assign stop_hit = (motor_speed < eff_thr) || tmr_expired;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: if (cmd_on && !alarm_stop) next_state = ST_RUN;
         ST_RUN: begin
            if (zero_stop) begin
               next_state = ST_ZERO_DECEL;
            end else if (alarm_stop) begin
               next_state = standstill ? ST_OFF : ST_ROT_COAST;
            end else if (cmd_off) begin
               next_state = standstill ? ST_STOP_DELAY
                                       : ST_ROT_COAST;
            end
         end
         ST_STOP_DELAY: if ((alarm_stop && !zero_stop) || tmr_expired)
            next_state = ST_OFF;
         ST_ROT_COAST: if (stop_hit) next_state = ST_OFF;
         ST_ZERO_DECEL: if (standstill)
            next_state = ST_STOP_DELAY;
         default: next_state = ST_OFF;
      endcase
   end

   // delay and wait settings are sampled when a timed phase starts
   assign tmr_start = (next_state != state) &&
      (next_state == ST_STOP_DELAY || next_state == ST_ROT_COAST);
   assign tmr_load = (next_state == ST_STOP_DELAY) ? {1'b0, cfg.dexc}
                                                   : cfg.wait_t;

   // state register
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // drive outputs from the state being entered
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         brake_release <= 1'b0;
         excite <= 1'b0;
         zero_speed_cmd <= 1'b0;
      end else begin
         brake_release <= (next_state == ST_RUN) ||
            (next_state == ST_ROT_COAST) ||
            (next_state == ST_ZERO_DECEL);
         excite <= (next_state == ST_RUN) ||
            (next_state == ST_STOP_DELAY) ||
            (next_state == ST_ZERO_DECEL);
         zero_speed_cmd <= (next_state == ST_ZERO_DECEL);
      end
   end

   // ----------------------------------------------------------------
   // time base and phase timer
   // ----------------------------------------------------------------
   tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .sys_clk(sys_clk), .sys_rst(sys_rst),
      .restart(tmr_start), .tick(tick)
   );

   delay_timer #(.CNT_W(7)) u_timer (
      .sys_clk(sys_clk), .sys_rst(sys_rst),
      .start(tmr_start), .load(tmr_load),
      .tick(tick), .expired(tmr_expired)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence still_off_s;
      state == ST_RUN && !alarm_stop && cmd_off && standstill;
   endsequence

   sequence rot_off_s;
      state == ST_RUN && !alarm_stop && cmd_off && !standstill;
   endsequence

   brake_at_once_a: assert property (
      still_off_s |=> !brake_release && excite && state == ST_STOP_DELAY)
      else $error("brake not engaged at standstill servo-off");
   excite_hold_a: assert property (
      state == ST_STOP_DELAY && !tmr_expired && !alarm_stop |=> excite)
      else $error("excitation dropped before delay ended");
   rotating_path_a: assert property (
      rot_off_s |=> state == ST_ROT_COAST && brake_release && !excite)
      else $error("rotating servo-off took the standstill path");
   alarm_rotate_a: assert property (
      state == ST_RUN && alarm_stop && !zero_stop && !standstill
      |=> state == ST_ROT_COAST ##1 (!brake_release || state == ST_ROT_COAST))
      else $error("alarm during rotation not handled as stop");
   speed_engage_a: assert property (
      state == ST_ROT_COAST && motor_speed < eff_thr
      |=> !brake_release && !excite && state == ST_OFF)
      else $error("brake not engaged below speed threshold");
   wait_engage_a: assert property (
      state == ST_ROT_COAST && tmr_expired |=> !brake_release)
      else $error("brake not engaged at wait expiry");
   thr_limit_a: assert property (
      state == ST_ROT_COAST && cfg.thr > cfg.max_spd &&
         motor_speed < cfg.max_spd |=> state == ST_OFF && !brake_release)
      else $error("threshold not limited to maximum speed");
   zero_decel_a: assert property (
      state == ST_ZERO_DECEL && standstill |=> state == ST_STOP_DELAY &&
         excite && !brake_release && !zero_speed_cmd)
      else $error("zero-speed stop did not enter standstill delay");
   still_hold_a: assert property (
      state == ST_ROT_COAST && !stop_hit |=> brake_release)
      else $error("brake engaged before either stop condition");
   load_now_a: assert property (
      tmr_start && next_state == ST_ROT_COAST
      |=> u_timer.count == $past(cfg.wait_t))
      else $error("wait timer not loaded from current setting");

endmodule

//--- bench/motor_model.sv
// behavioural motor and drive stage seen by the brake sequencer
`timescale 1ns/1ps
module motor_model (
   // clock
   input wire logic sys_clk,
   // drive commands from the sequencer
   input wire logic excite,
   input wire logic zero_speed_cmd,
   // scenario knobs from the bench
   input wire logic [15:0] set_speed,
   input wire logic [15:0] coast_step,
   // measured speed
   output logic [15:0] motor_speed
);
   // excited drive tracks the set speed, otherwise it slows by coast_step
   // each cycle; a zero-speed command decelerates the same way
   initial motor_speed = 16'h0000;
   always @(posedge sys_clk) begin
      if (excite && !zero_speed_cmd) begin
         motor_speed <= set_speed;
      end else if (motor_speed > coast_step) begin
         motor_speed <= motor_speed - coast_step;
      end else begin
         motor_speed <= 16'h0000;
      end
   end
endmodule

//--- bench/brake_seq_tb.sv
// self-checking bench for the holding brake sequencer
`timescale 1ns/1ps
module brake_seq_tb;
   import brake_seq_pkg::*;
   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic [1:0] s;
   } row_s;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   axi_req_s req = '0;
   axi_rsp_s rsp;
   logic [15:0] motor_speed;
   logic alarm_stop = 1'b0;
   logic alarm_class2 = 1'b0;
   logic brake_release, excite, zero_speed_cmd;
   logic [15:0] set_speed = 16'h0000;
   logic [15:0] coast_step = 16'h000a;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [1:0] r;
   logic [31:0] q;
   row_s rows [10] = '{
      '{1'b0, 8'h04, 32'h0, 32'h0, 2'h0}, '{1'b0, 8'h08, 32'h0, 32'h64, 2'h0},
      '{1'b0, 8'h0c, 32'h0, 32'h32, 2'h0}, '{1'b0, 8'h10, 32'h0, 32'h0, 2'h0},
      '{1'b0, 8'h14, 32'h0, 32'h1770, 2'h0}, '{1'b1, 8'h1c, 32'h5, 32'h0, 2'h2},
      '{1'b1, 8'h04, 32'hff, 32'h32, 2'h0}, '{1'b1, 8'h0c, 32'h1, 32'ha, 2'h0},
      '{1'b1, 8'h08, 32'hffff, 32'h2710, 2'h0},
      '{1'b1, 8'h18, 32'hff, 32'h40, 2'h0}};

   // ----------------------------------------------------------------
   // clock, design, partner and watchdog
   // ----------------------------------------------------------------
   always #5 sys_clk = ~sys_clk;
   brake_seq #(.TICK_CYCLES(10)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .axi_req(req), .axi_rsp(rsp), .motor_speed(motor_speed),
      .alarm_stop(alarm_stop), .alarm_class2(alarm_class2),
      .brake_release(brake_release), .excite(excite),
      .zero_speed_cmd(zero_speed_cmd));
   motor_model motor (.sys_clk(sys_clk), .excite(excite),
      .zero_speed_cmd(zero_speed_cmd), .set_speed(set_speed),
      .coast_step(coast_step), .motor_speed(motor_speed));
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic go(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) begin
            r = rsp.bresp;
            req.bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) begin
            q = rsp.rdata;
            r = rsp.rresp;
            req.rready <= 1'b0;
            break;
         end
      end
   endtask
   // servo-on at the given speed, then servo-off; returns when outputs moved
   task automatic run_off(input logic [15:0] spd, input logic [15:0] st);
      set_speed <= spd;
      coast_step <= st;
      wr(8'h00, 32'h31);
      go(5);
      wr(8'h00, 32'h32);
      go(1);
   endtask
   task automatic close_out();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      go(20);
      chk({brake_release, excite, rsp.awready}, 3'b001);
      sys_rst <= 1'b0;
      // settings: reset values, clamping, unmapped and read-only places
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         if (rows[i].w) chk(r, rows[i].s);
         rd(rows[i].a);
         chk(q, rows[i].e);
         chk(r, rows[i].s);
      end
      wr(8'h04, 32'h0);
      wr(8'h0c, 32'h32);
      wr(8'h08, 32'h64);
      // standstill servo-off, no delay then a 3-tick delay
      run_off(16'h0, 16'ha);
      chk({brake_release, excite}, 2'b01);
      go(2);
      chk(excite, 1'b0);
      wr(8'h04, 32'h3);
      run_off(16'h0, 16'ha);
      chk(brake_release, 1'b0);
      go(25);
      chk(excite, 1'b1);
      go(10);
      chk(excite, 1'b0);
      wr(8'h04, 32'h0);
      // rotating servo-off ends on the speed threshold
      run_off(16'd1000, 16'ha);
      chk({brake_release, excite, zero_speed_cmd}, 3'b100);
      go(80);
      chk(brake_release, 1'b1);
      go(20);
      chk(brake_release, 1'b0);
      // rotating servo-off ends on the wait timer with no slowdown
      wr(8'h0c, 32'ha);
      run_off(16'd1000, 16'h0);
      go(90);
      chk(brake_release, 1'b1);
      go(20);
      chk(brake_release, 1'b0);
      // threshold above maximum speed is limited to the maximum
      wr(8'h08, 32'd9000);
      wr(8'h14, 32'd5000);
      wr(8'h0c, 32'h64);
      run_off(16'd7000, 16'ha);
      go(100);
      chk(brake_release, 1'b1);
      go(120);
      chk(brake_release, 1'b0);
      wr(8'h08, 32'h64);
      wr(8'h14, 32'h1770);
      // class-1 alarm while rotating coasts then engages the brake
      set_speed <= 16'd1000;
      wr(8'h00, 32'h31);
      go(5);
      alarm_stop <= 1'b1;
      go(3);
      chk({brake_release, excite}, 2'b10);
      go(100);
      chk(brake_release, 1'b0);
      alarm_stop <= 1'b0;
      // zero-speed class-2 stop decelerates, then standstill delay
      wr(8'h10, 32'h1);
      alarm_class2 <= 1'b1;
      wr(8'h00, 32'h31);
      go(5);
      alarm_stop <= 1'b1;
      go(3);
      chk({brake_release, excite, zero_speed_cmd}, 3'b111);
      go(110);
      chk({brake_release, excite, zero_speed_cmd}, 3'b000);
      // reset in mid-run while running returns outputs and settings
      alarm_stop <= 1'b0;
      alarm_class2 <= 1'b0;
      wr(8'h00, 32'h31);
      go(3);
      sys_rst <= 1'b1;
      go(2);
      chk({brake_release, excite, zero_speed_cmd, rsp.awready, rsp.arready,
         rsp.bvalid, rsp.rvalid}, 7'b0001100);
      sys_rst <= 1'b0;
      rd(8'h10);
      chk(q, 32'h0);
      chk(r, 2'b00);
      close_out();
   end
endmodule
